// ===== hw/amc_strobe_timing.sv
// async memory strobe timing controller: one access per request, setup/strobe/hold phases
// assumes requester holds req_valid_in until req_ready_out; memory data input is asynchronous
`timescale 1ns/1ps
module amc_strobe_timing (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // configuration
   input wire amc_pkg::amc_config_s config_in,
   // request port
   input wire logic req_valid_in,
   input wire amc_pkg::amc_req_s req_in,
   output logic req_ready_out,
   output logic rdata_valid_out,
   output logic [amc_pkg::DATA_W-1:0] rdata_out,
   // external memory pins
   output logic ext_chip_select_n_out,
   output logic ext_output_enable_n_out,
   output logic ext_write_enable_n_out,
   output logic [amc_pkg::ADDR_W-1:0] ext_addr_out,
   output logic ext_cmd_latch_out,
   output logic ext_addr_latch_out,
   output logic [amc_pkg::DATA_W-1:0] ext_data_out,
   output logic ext_data_oe_n_out,
   input wire logic [amc_pkg::DATA_W-1:0] ext_data_in,
   input wire logic ext_wait_input_in
);
   typedef struct packed {
      amc_pkg::amc_state_e state;
      logic [amc_pkg::FIELD_W-1:0] count;
      logic last_read;
      logic write;
      logic cs_n;
      logic oe_n;
      logic we_n;
      logic drive_n;
      logic cle;
      logic ale;
      logic ready;
      logic rvalid;
      logic [amc_pkg::ADDR_W-1:0] addr;
      logic [amc_pkg::DATA_W-1:0] wdata;
      logic [amc_pkg::DATA_W-1:0] rdata;
      logic [amc_pkg::DATA_W-1:0] sync1;
      logic [amc_pkg::DATA_W-1:0] sync2;
      logic wsync1;
      logic wsync2;
   } amc_st_s;

   amc_st_s st;
   amc_st_s next_st;
   amc_pkg::amc_timing_s tim;

   // mask a bus value to the selected width
   function automatic logic [amc_pkg::DATA_W-1:0] amc_width(input logic wide, input logic [amc_pkg::DATA_W-1:0] v);
      amc_width = wide ? v : {8'h00, v[7:0] & amc_pkg::BYTE_MASK};
   endfunction

   assign tim = st.write ? config_in.wr : config_in.rd;

   // next state of the access sequencer
   always_comb begin
      next_st = st;
      next_st.rvalid = 1'b0;
      next_st.sync1 = ext_data_in;
      next_st.sync2 = st.sync1;
      next_st.wsync1 = ext_wait_input_in;
      next_st.wsync2 = st.wsync1;
      case (st.state)
         amc_pkg::AMC_IDLE: begin
            next_st.ready = 1'b1;
            if (req_valid_in && st.ready) begin
               next_st.ready = 1'b0;
               // command and address forced to write
               next_st.write = req_in.write || (req_in.kind != amc_pkg::AMC_KIND_DATA);
               next_st.addr = req_in.addr;
               next_st.wdata = amc_width(config_in.bus_width_select, req_in.wdata);
               next_st.cle = config_in.flash_mode && (req_in.kind == amc_pkg::AMC_KIND_CMD);
               next_st.ale = config_in.flash_mode && (req_in.kind == amc_pkg::AMC_KIND_ADDR);
               next_st.cs_n = 1'b0;
               if (st.last_read && next_st.write) begin
                  next_st.state = amc_pkg::AMC_TURN;
                  next_st.count = config_in.turnaround_cycles;
               end else begin
                  next_st.state = amc_pkg::AMC_SETUP;
                  next_st.count = next_st.write ? config_in.wr.setup : config_in.rd.setup;
               end
            end
         end
         amc_pkg::AMC_TURN: begin
            if (st.count == amc_pkg::CNT_RESET) begin
               next_st.state = amc_pkg::AMC_SETUP;
               next_st.count = tim.setup;
            end else begin
               next_st.count = st.count - 4'h1;
            end
         end
         amc_pkg::AMC_SETUP: begin
            next_st.drive_n = ~st.write;
            if (st.count == amc_pkg::CNT_RESET) begin
               next_st.state = amc_pkg::AMC_STROBE;
               next_st.count = tim.strobe;
               next_st.we_n = ~st.write;
               next_st.oe_n = st.write;
            end else begin
               next_st.count = st.count - 4'h1;
            end
         end
         amc_pkg::AMC_STROBE: begin
            if (config_in.extended_wait_enable && !st.wsync2) begin
               next_st.count = st.count;
            end else if (st.count == amc_pkg::CNT_RESET) begin
               next_st.state = amc_pkg::AMC_HOLD;
               next_st.count = tim.hold;
               next_st.we_n = 1'b1;
               next_st.oe_n = 1'b1;
               if (!st.write) begin
                  next_st.rdata = amc_width(config_in.bus_width_select, st.sync2);
                  next_st.rvalid = 1'b1;
               end
            end else begin
               next_st.count = st.count - 4'h1;
            end
         end
         amc_pkg::AMC_HOLD: begin
            if (st.count == amc_pkg::CNT_RESET) begin
               next_st.state = amc_pkg::AMC_IDLE;
               next_st.cs_n = 1'b1;
               next_st.drive_n = 1'b1;
               next_st.cle = 1'b0;
               next_st.ale = 1'b0;
               next_st.last_read = ~st.write;
            end else begin
               next_st.count = st.count - 4'h1;
            end
         end
         default: begin
            next_st.state = amc_pkg::AMC_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st <= '{state: amc_pkg::AMC_IDLE, count: amc_pkg::CNT_RESET, last_read: 1'b0, write: 1'b0,
                 cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, drive_n: 1'b1, cle: 1'b0, ale: 1'b0,
                 ready: 1'b0, rvalid: 1'b0, addr: '0, wdata: amc_pkg::DATA_RESET,
                 rdata: amc_pkg::DATA_RESET, sync1: amc_pkg::DATA_RESET, sync2: amc_pkg::DATA_RESET,
                 wsync1: 1'b0, wsync2: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from state flops
   assign req_ready_out = st.ready;
   assign rdata_valid_out = st.rvalid;
   assign rdata_out = st.rdata;
   assign ext_chip_select_n_out = st.cs_n;
   assign ext_output_enable_n_out = st.oe_n;
   assign ext_write_enable_n_out = st.we_n;
   assign ext_addr_out = st.addr;
   assign ext_cmd_latch_out = st.cle;
   assign ext_addr_latch_out = st.ale;
   assign ext_data_out = st.wdata;
   assign ext_data_oe_n_out = st.drive_n;

   // strobe never active while chip select is high
   property p_strobe_in_cs;
      @(posedge clk_in) disable iff (!reset_n_in)
      (!st.we_n || !st.oe_n) |-> !st.cs_n;
   endproperty
   a_strobe_in_cs: assert property (p_strobe_in_cs) else $error("strobe outside chip select");

   // setup of zero: strobe right after setup entry
   property p_setup_len;
      @(posedge clk_in) disable iff (!reset_n_in)
      (st.state == amc_pkg::AMC_SETUP && st.count == amc_pkg::CNT_RESET) |=> st.state == amc_pkg::AMC_STROBE;
   endproperty
   a_setup_len: assert property (p_setup_len) else $error("setup phase length wrong");

   // command and address phases write
   property p_cmd_write;
      @(posedge clk_in) disable iff (!reset_n_in)
      (st.cle || st.ale) |-> st.write;
   endproperty
   a_cmd_write: assert property (p_cmd_write) else $error("flash cmd or addr not a write");

   // write data not driven during turnaround
   property p_turn_nodrive;
      @(posedge clk_in) disable iff (!reset_n_in)
      st.state == amc_pkg::AMC_TURN |-> st.drive_n;
   endproperty
   a_turn_nodrive: assert property (p_turn_nodrive) else $error("data driven in turnaround");

   // read never drives bus
   property p_read_nodrive;
      @(posedge clk_in) disable iff (!reset_n_in)
      !st.oe_n |-> st.drive_n;
   endproperty
   a_read_nodrive: assert property (p_read_nodrive) else $error("bus contention on read");

   // 8-bit mode read data upper byte zero
   property p_narrow;
      @(posedge clk_in) disable iff (!reset_n_in)
      (st.rvalid && !config_in.bus_width_select) |-> st.rdata[15:8] == 8'h00;
   endproperty
   a_narrow: assert property (p_narrow) else $error("upper byte in 8-bit mode");

   // no stretch when wait disabled
   property p_no_wait;
      @(posedge clk_in) disable iff (!reset_n_in)
      (st.state == amc_pkg::AMC_STROBE && !config_in.extended_wait_enable && st.count != 4'h0)
         |=> st.count == $past(st.count) - 4'h1;
   endproperty
   a_no_wait: assert property (p_no_wait) else $error("strobe stretched without wait");

   // latch signals only on flash spaces
   property p_flash_only;
      @(posedge clk_in) disable iff (!reset_n_in)
      (st.state == amc_pkg::AMC_IDLE && req_valid_in && st.ready && !config_in.flash_mode)
         |=> !st.cle && !st.ale;
   endproperty
   a_flash_only: assert property (p_flash_only) else $error("latch on non-flash space");

   // last strobe cycle that is not stalled, then hold with strobes released and chip select low
   sequence s_strobe_last;
      st.state == amc_pkg::AMC_STROBE && st.count == amc_pkg::CNT_RESET
         && !(config_in.extended_wait_enable && !st.wsync2);
   endsequence
   sequence s_hold_open;
      st.state == amc_pkg::AMC_HOLD && st.we_n && st.oe_n && !st.cs_n;
   endsequence
   property p_hold_order;
      @(posedge clk_in) disable iff (!reset_n_in)
      s_strobe_last |=> s_hold_open;
   endproperty
   a_hold_order: assert property (p_hold_order) else $error("hold phase order wrong");
endmodule

// ===== hw/amc_pkg.sv
// package for the async memory strobe timing block: field layouts, widths, states
// assumes a single 125 MHz controller clock
package amc_pkg;
   localparam int FIELD_W = 4;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [FIELD_W-1:0] CNT_RESET = 4'h0;
   localparam logic [7:0] BYTE_MASK = 8'hFF;

   // phase lengths for one direction, each field is cycles minus one
   typedef struct packed {
      logic [FIELD_W-1:0] setup;
      logic [FIELD_W-1:0] strobe;
      logic [FIELD_W-1:0] hold;
   } amc_timing_s;

   // per-space configuration
   typedef struct packed {
      logic strobe_select;
      logic extended_wait_enable;
      logic bus_width_select;
      logic flash_mode;
      logic [FIELD_W-1:0] turnaround_cycles;
      amc_timing_s rd;
      amc_timing_s wr;
   } amc_config_s;

   // flash phase kinds carried with a request
   typedef enum logic [1:0] {
      AMC_KIND_DATA,
      AMC_KIND_CMD,
      AMC_KIND_ADDR
   } amc_kind_e;

   // one single asynchronous access request
   typedef struct packed {
      logic write;
      amc_kind_e kind;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } amc_req_s;

   typedef enum logic [2:0] {
      AMC_IDLE,
      AMC_TURN,
      AMC_SETUP,
      AMC_STROBE,
      AMC_HOLD
   } amc_state_e;
endpackage

// ===== test/amc_mem_model.sv
// async memory model for the strobe timing bench, sixteen words
// assumes active-low strobes; the data lines show inverted last value when released
`timescale 1ns/1ps
module amc_mem_model (
   // controller pins
   input wire logic cs_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   input wire logic [15:0] addr_in,
   input wire logic [15:0] data_in,
   input wire logic drive_n_in,
   // data back to the controller
   output logic [15:0] data_out
);
   logic [15:0] mem [16];
   logic [15:0] last = 16'h0000;
   always @* begin
      if (!cs_n_in && !we_n_in && !drive_n_in) begin
         mem[addr_in[3:0]] = data_in;
      end
   end
   always @* begin
      if (!cs_n_in && !oe_n_in) begin
         last = mem[addr_in[3:0]];
      end
   end
   // released bus never shows a stale value
   assign data_out = (!cs_n_in && !oe_n_in) ? mem[addr_in[3:0]] : ~last;
endmodule

// ===== test/tb_async_memory_strobe_timing.sv
// self-checking bench for the async memory strobe timing block
// assumes the memory model on the far side and 125 MHz clock
`timescale 1ns/1ps
module tb_async_memory_strobe_timing;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   amc_pkg::amc_config_s cfg = '0;
   amc_pkg::amc_req_s req = '0;
   logic req_valid_in = 1'b0;
   logic wait_in = 1'b1;
   logic ready, rvalid, cs_n, oe_n, we_n, cle, ale, drv_n, doe, cl, al;
   logic [15:0] rdata, addr, dout, din, wd, rd;
   int n_fail = 0;
   int checks = 0;
   int n_set, n_we, n_oe, n_hold, n_nodrv;
   always #4 clk_in = ~clk_in;
   amc_strobe_timing uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .config_in(cfg),
      .req_valid_in(req_valid_in), .req_in(req), .req_ready_out(ready), .rdata_valid_out(rvalid),
      .rdata_out(rdata), .ext_chip_select_n_out(cs_n), .ext_output_enable_n_out(oe_n),
      .ext_write_enable_n_out(we_n), .ext_addr_out(addr), .ext_cmd_latch_out(cle),
      .ext_addr_latch_out(ale), .ext_data_out(dout), .ext_data_oe_n_out(drv_n),
      .ext_data_in(din), .ext_wait_input_in(wait_in));
   amc_mem_model u_mem (.cs_n_in(cs_n), .oe_n_in(oe_n), .we_n_in(we_n), .addr_in(addr),
      .data_in(dout), .drive_n_in(drv_n), .data_out(din));
   // compare and count
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one access: hold request until taken, then count phases at falling edges
   task automatic run(input logic w, input amc_pkg::amc_kind_e k, input logic [15:0] a,
                      input logic [15:0] d);
      n_set = 0;
      n_we = 0;
      n_oe = 0;
      n_hold = 0;
      n_nodrv = 0;
      @(negedge clk_in);
      req = '{w, k, a, d};
      req_valid_in = 1'b1;
      // look at ready where it is settled; the rising edge after it stands takes the request
      for (int i = 0; i < 40 && ready !== 1'b1; i++) begin
         @(negedge clk_in);
      end
      @(posedge clk_in);
      @(negedge clk_in);
      req_valid_in = 1'b0;
      for (int i = 0; i < 80 && cs_n === 1'b0; i++) begin
         if (rvalid === 1'b1) rd = rdata;
         if (we_n === 1'b0) begin
            n_we++;
            wd = dout;
            doe = drv_n;
            cl = cle;
            al = ale;
         end else if (oe_n === 1'b0) begin
            n_oe++;
         end else if (n_we + n_oe == 0) begin
            n_set++;
            if (drv_n === 1'b1) n_nodrv++;
         end else begin
            n_hold++;
         end
         @(negedge clk_in);
      end
   endtask
   // write with the wait input held low
   task automatic t_write();
      wait_in = 1'b0;
      run(1'b1, amc_pkg::AMC_KIND_DATA, 16'h0005, 16'ha55a);
      check("wr setup", 16'(n_set), 16'h0002);
      check("wr strobe", 16'(n_we), 16'h0004);
      check("wr hold", 16'(n_hold), 16'h0003);
      check("wr oe", 16'(n_oe), 16'h0000);
      check("wr data", wd, 16'ha55a);
      check("wr drive", 16'(doe), 16'h0000);
      wait_in = 1'b1;
      $display("done write");
   endtask
   // read back with the read timing set
   task automatic t_read();
      run(1'b0, amc_pkg::AMC_KIND_DATA, 16'h0005, 16'h0000);
      check("rd setup", 16'(n_set), 16'h0003);
      check("rd strobe", 16'(n_oe), 16'h0005);
      check("rd hold", 16'(n_hold), 16'h0001);
      check("rd we", 16'(n_we), 16'h0000);
      check("rd data", rd, 16'ha55a);
      $display("done read");
   endtask
   // write straight after a read waits out the turnaround
   task automatic t_turn();
      run(1'b1, amc_pkg::AMC_KIND_DATA, 16'h0007, 16'h0f0f);
      check("turn setup", 16'(n_set), 16'h0005);
      check("turn undriven", 16'(n_nodrv >= 3), 16'h0001);
      check("turn data", wd, 16'h0f0f);
      $display("done turnaround");
   endtask
   // flash phases as single accesses, command and address always writes
   task automatic t_flash();
      cfg.flash_mode = 1'b1;
      run(1'b0, amc_pkg::AMC_KIND_CMD, 16'h0000, 16'h0090);
      check("cmd strobe", 16'(n_we), 16'h0004);
      check("cmd latch", {14'h0000, cl, al}, 16'h0002);
      run(1'b0, amc_pkg::AMC_KIND_ADDR, 16'h0000, 16'h0012);
      check("addr strobe", 16'(n_we + n_oe), 16'h0004);
      check("addr latch", {14'h0000, cl, al}, 16'h0001);
      run(1'b0, amc_pkg::AMC_KIND_DATA, 16'h0007, 16'h0000);
      check("fdata strobe", 16'(n_oe), 16'h0005);
      check("fdata read", rd, 16'h0f0f);
      cfg.flash_mode = 1'b0;
      run(1'b1, amc_pkg::AMC_KIND_CMD, 16'h0001, 16'h0033);
      check("plain latch", {14'h0000, cl, al}, 16'h0000);
      $display("done flash");
   endtask
   // narrow bus keeps the low byte only
   task automatic t_byte();
      cfg.bus_width_select = 1'b0;
      run(1'b1, amc_pkg::AMC_KIND_DATA, 16'h0006, 16'h1234);
      check("byte write", wd, 16'h0034);
      run(1'b0, amc_pkg::AMC_KIND_DATA, 16'h0007, 16'h0000);
      check("byte read", rd, 16'h000f);
      $display("done byte");
   endtask
   // extended wait on: a low wait input stretches the read strobe by five cycles
   task automatic t_wait();
      cfg.extended_wait_enable = 1'b1;
      wait_in = 1'b0;
      fork
         run(1'b0, amc_pkg::AMC_KIND_DATA, 16'h0006, 16'h0000);
         begin
            repeat (8) @(negedge clk_in);
            wait_in = 1'b1;
         end
      join
      check("wait strobe", 16'(n_oe), 16'h000a);
      check("wait data", rd, 16'h0034);
      cfg.extended_wait_enable = 1'b0;
      $display("done wait");
   endtask
   // verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      #20000;
      n_fail++;
      final_report();
   end
   // main sequence; normal strobe, timings with margin
   initial begin
      cfg.bus_width_select = 1'b1;
      cfg.turnaround_cycles = 4'h2;
      cfg.rd = '{4'h2, 4'h4, 4'h0};
      cfg.wr = '{4'h1, 4'h3, 4'h2};
      repeat (5) @(negedge clk_in);
      reset_n_in = 1'b1;
      t_write();
      t_read();
      t_turn();
      t_flash();
      t_byte();
      t_wait();
      final_report();
   end
endmodule
